// *** rtl/serial_bus_pkg.sv ***
// Constants, types and timing for the two-wire serial bus master.
package serial_bus_pkg;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 25000;
    // A quarter of one serial bit; four quarters give close to 100 kHz.
    localparam int QUARTER_NS   = 2500;
    // Least time, so rounded up to whole cycles.
    localparam int QUARTER_CYC  = (QUARTER_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    // Cycles after reset release before the straps are taken.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ------------------------------------------------------------------
    // Status byte layout.
    // ------------------------------------------------------------------
    localparam int LOAD_ERR_BIT   = 0;
    localparam int NACK_ERR_BIT   = 1;
    localparam int BUS_DETECT_BIT = 3;
    localparam int REQ_BUSY_BIT   = 5;

    // ------------------------------------------------------------------
    // Serial EEPROM loader layout.
    // ------------------------------------------------------------------
    localparam logic [6:0] EEPROM_ADDR  = 7'h50;
    localparam logic [7:0] END_OF_LIST  = 8'hff;
    localparam logic [7:0] REF_FIRST    = 8'h01;
    localparam logic [7:0] REF_LAST     = 8'h04;
    localparam logic [7:0] ENTRY_STRIDE = 8'h08;
    localparam logic [2:0] DATA_BYTES   = 3'h4;
    localparam logic [3:0] ACK_SLOT     = 4'h8;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SYM_START, SYM_TX, SYM_RX, SYM_STOP} sym_t;

    typedef struct packed {
        logic [6:0] targetAddressField;
        logic       directionBit;
        logic [7:0] index;
        logic [7:0] data;
    } sw_req_t;

    typedef struct packed {
        logic [7:0]  offsetRef;
        logic [31:0] word;
    } load_out_t;

endpackage

// *** rtl/serial_bus_master.sv ***
// Two-wire serial bus master with software byte access and EEPROM loader.
`timescale 1ns/10ps

// Functional notes
// - Both strap pins pulled up at reset sets the bus detect flag.
// - Bus detect flag clears only on a written one.
// - When detected, clock goes to shared pin 4, data to shared pin 1.
// - Serial clock runs close to 100 kHz during transfers.
// - Both lines are open drain: pulled low or released.
// - At most 100 kbit/s, seven-bit slave addresses only.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.
// - Data changes only while the clock is low.
// - Eight-bit bytes, each followed by one acknowledge bit.
// - Acknowledge is data held low through the ninth clock high.
// - This block is the only master and makes the clock.
// - Clock line released and still when no cycle runs.
// - Software does byte reads and writes; loader alone does multi-byte reads.
// - Byte write: start, address, write bit, index, data, acknowledges, stop.
// - Missing acknowledge sets an error status bit.
// - Byte read follows the write sequence with direction one; code does address, write bit, index, restart, address, read bit, data, stop.
// - As receiver the master drives the acknowledge slot.
// - Slave drives data during read bits; master keeps the clock.
// - A slave address write launches a transaction with address and direction.
// - Busy flag set while a request runs, cleared after read data stored.
// - Loader reads offset references and four data bytes, ends at FFh.
// - Undefined EEPROM content aborts loading and sets the load error flag.
module serial_bus_master (
    // Clock and reset.
    input  wire logic                      clock,
    input  wire logic                      reset,
    // Strap pins, sampled after reset.
    input  wire logic                      strapPinA,
    input  wire logic                      strapPinB,
    // Shared pin 1 carries serial data.
    input  wire logic                      sharedPin1In,
    output wire logic                      sharedPin1Out,
    output wire logic                      sharedPin1Oe,
    // Shared pin 4 carries serial clock.
    input  wire logic                      sharedPin4In,
    output wire logic                      sharedPin4Out,
    output wire logic                      sharedPin4Oe,
    // Software request, one pulse per slave address write.
    input  wire logic                      swReqValid,
    input  wire serial_bus_pkg::sw_req_t   swReq,
    // Status byte write, ones clear flags.
    input  wire logic                      statusWrite,
    input  wire logic [7:0]                statusWdata,
    // Status and received data.
    output logic      [7:0]                ctlStatus,
    output wire logic [7:0]                readData,
    // Loader results.
    output wire logic                      loaderBusy,
    output wire logic                      loadValid,
    output wire serial_bus_pkg::load_out_t loadOut
);

    typedef enum {ST_IDLE, ST_START, ST_SLAW, ST_INDEX, ST_WDATA,
                  ST_RESTART, ST_SLAR, ST_RDATA, ST_STOP} state_t;

    // ------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------
    logic [1:0] strapASync_q;
    logic [1:0] strapBSync_q;
    logic [1:0] sdaSync_q;
    logic [1:0] sclSync_q;

    // Every pin passes two flip-flops before any logic reads it.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strapASync_q <= 2'h0;
            strapBSync_q <= 2'h0;
            sdaSync_q    <= 2'h3;
            sclSync_q    <= 2'h3;
        end else begin
            strapASync_q <= {strapASync_q[0], strapPinA};
            strapBSync_q <= {strapBSync_q[0], strapPinB};
            sdaSync_q    <= {sdaSync_q[0], sharedPin1In};
            sclSync_q    <= {sclSync_q[0], sharedPin4In};
        end
    end

    // ------------------------------------------------------------------
    // Strap capture.
    // ------------------------------------------------------------------
    logic [1:0] settle_q;
    logic       strapDone_q;
    logic       detected_q;
    logic       strapCaught;
    logic       bothHigh;

    assign strapCaught = !strapDone_q && (settle_q == serial_bus_pkg::STRAP_SETTLE);
    assign bothHigh    = strapASync_q[1] && strapBSync_q[1];

    // Straps are taken once, a few cycles after reset release.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            settle_q    <= 2'h0;
            strapDone_q <= 1'b0;
            detected_q  <= 1'b0;
        end else if (!strapDone_q) begin
            settle_q <= settle_q + 2'h1;
            if (strapCaught) begin
                strapDone_q <= 1'b1;
                detected_q  <= bothHigh;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bit engine.
    // ------------------------------------------------------------------
    state_t               state_q;
    serial_bus_pkg::sym_t sym;
    logic [5:0]           tick_q;
    logic [1:0]           quarter_q;
    logic [3:0]           bitIdx_q;
    logic [7:0]           rx_q;
    logic                 ackSeen_q;
    logic                 sclLow_q;
    logic                 sdaLow_q;
    logic                 sclLowD;
    logic                 sdaLowD;
    logic                 tickEnd;
    logic                 stretchWait;
    logic                 bitStep;
    logic                 symDone;
    logic [7:0]           txByte;
    logic [7:0]           txShifted;
    logic                 lastByte;

    // Symbol issued by each sequencer state.
    always_comb begin
        case (state_q)
            ST_START, ST_RESTART: sym = serial_bus_pkg::SYM_START;
            ST_RDATA:             sym = serial_bus_pkg::SYM_RX;
            ST_STOP, ST_IDLE:     sym = serial_bus_pkg::SYM_STOP;
            default:              sym = serial_bus_pkg::SYM_TX;
        endcase
    end

    assign tickEnd     = tick_q == 6'(serial_bus_pkg::QUARTER_CYC - 1);
    assign stretchWait = !sclLow_q && !sclSync_q[1];
    assign bitStep     = (state_q != ST_IDLE) && tickEnd && !stretchWait;
    assign symDone     = bitStep && (quarter_q == 2'h3)
                         && (sym == serial_bus_pkg::SYM_START
                             || sym == serial_bus_pkg::SYM_STOP
                             || bitIdx_q == serial_bus_pkg::ACK_SLOT);

    // Quarter-bit divider from the host clock; waits while the released clock line still reads low.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tick_q <= 6'h0;
        end else if (state_q == ST_IDLE || tickEnd) begin
            tick_q <= 6'h0;
        end else if (!stretchWait) begin
            tick_q <= tick_q + 6'h1;
        end
    end

    // Quarter and bit position within the current symbol.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quarter_q <= 2'h0;
            bitIdx_q  <= 4'h0;
        end else if (state_q == ST_IDLE) begin
            quarter_q <= 2'h0;
            bitIdx_q  <= 4'h0;
        end else if (bitStep) begin
            quarter_q <= quarter_q + 2'h1;
            if (quarter_q == 2'h3) begin
                bitIdx_q <= symDone ? 4'h0 : bitIdx_q + 4'h1;
            end
        end
    end

    // Data is sampled at the end of the clock high phase.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_q      <= 8'h0;
            ackSeen_q <= 1'b0;
        end else if (bitStep && quarter_q == 2'h2) begin
            if (bitIdx_q < serial_bus_pkg::ACK_SLOT) begin
                rx_q <= {rx_q[6:0], sdaSync_q[1]};
            end else begin
                ackSeen_q <= !sdaSync_q[1];
            end
        end
    end

    assign txShifted = txByte << bitIdx_q[2:0];

    // Line drives per quarter: data bits hold the clock low in quarters 3 and 0, high in 1 and 2; stop holds it low in quarter 0 only.
    always_comb begin
        sclLowD = 1'b0;
        sdaLowD = 1'b0;
        case (sym)
            serial_bus_pkg::SYM_START: begin
                sclLowD = (quarter_q == 2'h0) ? sclLow_q : (quarter_q == 2'h3);
                sdaLowD = quarter_q[1];
            end
            serial_bus_pkg::SYM_STOP: begin
                sclLowD = (state_q != ST_IDLE) && (quarter_q == 2'h0);
                sdaLowD = (state_q != ST_IDLE) && !quarter_q[1];
            end
            serial_bus_pkg::SYM_TX: begin
                sclLowD = (quarter_q == 2'h0) || (quarter_q == 2'h3);
                sdaLowD = (bitIdx_q < serial_bus_pkg::ACK_SLOT) && !txShifted[7];
            end
            serial_bus_pkg::SYM_RX: begin
                sclLowD = (quarter_q == 2'h0) || (quarter_q == 2'h3);
                sdaLowD = (bitIdx_q == serial_bus_pkg::ACK_SLOT) && !lastByte;
            end
            default: begin
                sclLowD = 1'b0;
                sdaLowD = 1'b0;
            end
        endcase
    end

    // Open-drain drive registers.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
        end else begin
            sclLow_q <= sclLowD;
            sdaLow_q <= sdaLowD;
        end
    end

    // Pins only pull low, and only once the bus has been detected.
    assign sharedPin4Out = 1'b0;
    assign sharedPin1Out = 1'b0;
    assign sharedPin4Oe  = detected_q && sclLow_q;
    assign sharedPin1Oe  = detected_q && sdaLow_q;

    // ------------------------------------------------------------------
    // Transaction sequencer.
    // ------------------------------------------------------------------
    serial_bus_pkg::sw_req_t   curReq_q;
    serial_bus_pkg::load_out_t loadOut_q;
    logic                      loading_q;
    logic                      busy_q;
    logic                      loadValid_q;
    logic [7:0]                base_q;
    logic [7:0]                lastRef_q;
    logic [2:0]                byteCnt_q;
    logic [31:0]               word_q;
    logic [7:0]                rdData_q;
    logic                      isRead;
    logic                      refOk;
    logic                      refBad;
    logic                      txState;
    logic                      nackEvent;

    assign isRead  = loading_q || curReq_q.directionBit;
    assign refOk   = rx_q >= serial_bus_pkg::REF_FIRST && rx_q <= serial_bus_pkg::REF_LAST
                     && rx_q > lastRef_q;
    assign txState = state_q == ST_SLAW || state_q == ST_INDEX
                     || state_q == ST_WDATA || state_q == ST_SLAR;
    assign nackEvent = symDone && txState && !ackSeen_q;
    assign refBad  = symDone && state_q == ST_RDATA && loading_q && byteCnt_q == 3'h0
                     && rx_q != serial_bus_pkg::END_OF_LIST && !refOk;

    // The last byte of a read takes no acknowledge so the slave frees the line.
    always_comb begin
        if (!loading_q) begin
            lastByte = 1'b1;
        end else if (byteCnt_q == 3'h0) begin
            lastByte = rx_q == serial_bus_pkg::END_OF_LIST || !refOk;
        end else begin
            lastByte = byteCnt_q == serial_bus_pkg::DATA_BYTES;
        end
    end

    // Byte sent in each transmit state.
    always_comb begin
        case (state_q)
            ST_SLAW: txByte = {loading_q ? serial_bus_pkg::EEPROM_ADDR
                                         : curReq_q.targetAddressField, 1'b0};
            ST_SLAR: txByte = {loading_q ? serial_bus_pkg::EEPROM_ADDR
                                         : curReq_q.targetAddressField, 1'b1};
            ST_INDEX: txByte = loading_q ? base_q : curReq_q.index;
            ST_WDATA: txByte = curReq_q.data;
            default:  txByte = 8'h0;
        endcase
    end

    // Step through start, address, index, data and stop for each transfer.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            curReq_q    <= '0;
            loading_q   <= 1'b0;
            busy_q      <= 1'b0;
            base_q      <= 8'h0;
            lastRef_q   <= 8'h0;
            byteCnt_q   <= 3'h0;
            word_q      <= 32'h0;
            rdData_q    <= 8'h0;
            loadOut_q   <= '0;
            loadValid_q <= 1'b0;
        end else begin
            loadValid_q <= 1'b0;
            if (strapCaught && bothHigh) begin
                loading_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (loading_q) begin
                        state_q <= ST_START;
                    end else if (swReqValid && detected_q) begin
                        curReq_q <= swReq;
                        busy_q   <= 1'b1;
                        state_q  <= ST_START;
                    end
                end
                ST_START: if (symDone) state_q <= ST_SLAW;
                ST_SLAW: if (symDone) state_q <= ackSeen_q ? ST_INDEX : ST_STOP;
                ST_INDEX: begin
                    if (symDone) begin
                        if (!ackSeen_q) begin
                            state_q <= ST_STOP;
                        end else begin
                            state_q <= isRead ? ST_RESTART : ST_WDATA;
                        end
                    end
                end
                ST_WDATA: if (symDone) state_q <= ST_STOP;
                ST_RESTART: if (symDone) state_q <= ST_SLAR;
                ST_SLAR: begin
                    if (symDone) begin
                        state_q   <= ackSeen_q ? ST_RDATA : ST_STOP;
                        byteCnt_q <= 3'h0;
                    end
                end
                ST_RDATA: begin
                    if (symDone) begin
                        if (!loading_q) begin
                            rdData_q <= rx_q;
                            state_q  <= ST_STOP;
                        end else if (byteCnt_q == 3'h0) begin
                            if (lastByte) begin
                                loading_q <= 1'b0;
                                state_q   <= ST_STOP;
                            end else begin
                                loadOut_q.offsetRef <= rx_q;
                                lastRef_q <= rx_q;
                                byteCnt_q <= 3'h1;
                            end
                        end else begin
                            word_q <= {word_q[23:0], rx_q};
                            if (lastByte) begin
                                loadOut_q.word <= {word_q[23:0], rx_q};
                                loadValid_q    <= 1'b1;
                                base_q         <= base_q + serial_bus_pkg::ENTRY_STRIDE;
                                state_q        <= ST_STOP;
                            end else begin
                                byteCnt_q <= byteCnt_q + 3'h1;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (symDone) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (nackEvent && loading_q) begin
                loading_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags; a set in the same cycle as a clear wins.
    // ------------------------------------------------------------------
    logic detectFlag_q;
    logic nackErr_q;
    logic loadErr_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            detectFlag_q <= 1'b0;
            nackErr_q    <= 1'b0;
            loadErr_q    <= 1'b0;
        end else begin
            if (strapCaught && bothHigh) begin
                detectFlag_q <= 1'b1;
            end else if (statusWrite && statusWdata[serial_bus_pkg::BUS_DETECT_BIT]) begin
                detectFlag_q <= 1'b0;
            end
            if (nackEvent && !loading_q) begin
                nackErr_q <= 1'b1;
            end else if (statusWrite && statusWdata[serial_bus_pkg::NACK_ERR_BIT]) begin
                nackErr_q <= 1'b0;
            end
            if (refBad || (nackEvent && loading_q)) begin
                loadErr_q <= 1'b1;
            end else if (statusWrite && statusWdata[serial_bus_pkg::LOAD_ERR_BIT]) begin
                loadErr_q <= 1'b0;
            end
        end
    end

    // Status byte assembled from the flags.
    always_comb begin
        ctlStatus = 8'h0;
        ctlStatus[serial_bus_pkg::LOAD_ERR_BIT]   = loadErr_q;
        ctlStatus[serial_bus_pkg::NACK_ERR_BIT]   = nackErr_q;
        ctlStatus[serial_bus_pkg::BUS_DETECT_BIT] = detectFlag_q;
        ctlStatus[serial_bus_pkg::REQ_BUSY_BIT]   = busy_q;
    end

    assign readData   = rdData_q;
    // The loader reads as busy until its closing stop has finished.
    assign loaderBusy = loading_q || (state_q != ST_IDLE && !busy_q);
    assign loadValid  = loadValid_q;
    assign loadOut    = loadOut_q;

endmodule

// *** dv/serial_bus_monitor.sv ***
// Port checker for the two-wire serial bus master.
`timescale 1ns/10ps
module serial_bus_monitor (
    // Clock and reset.
    input wire logic       clock,
    input wire logic       reset,
    // Requests and status writes.
    input wire logic       swReqValid,
    input wire logic       statusWrite,
    input wire logic [7:0] statusWdata,
    // Outputs under watch.
    input wire logic       sharedPin1Out,
    input wire logic       sharedPin1Oe,
    input wire logic       sharedPin4Out,
    input wire logic       sharedPin4Oe,
    input wire logic [7:0] ctlStatus,
    input wire logic       loaderBusy,
    input wire logic       loadValid
);
    // Every check runs on the host clock and rests during reset.
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    AST_OPEN_DRAIN: assert property (!sharedPin1Out && !sharedPin4Out)
        else $error("pin driven high");
    AST_START: assert property ($rose(sharedPin1Oe) && !sharedPin4Oe |->
        ##[62:64] $rose(sharedPin4Oe)) else $error("start not closed by clock low");
    AST_STOP: assert property ($fell(sharedPin1Oe) && !sharedPin4Oe |->
        $past(sharedPin4Oe, 100)) else $error("data rose with clock high outside stop");
    AST_LOW_PHASE: assert property ($rose(sharedPin4Oe) |->
        ##125 sharedPin4Oe ##1 !sharedPin4Oe) else $error("clock low phase wrong");
    AST_IDLE_FREE: assert property (!loaderBusy && !ctlStatus[5] |-> !sharedPin4Oe)
        else $error("clock pulled while idle");
    AST_TAKE: assert property (swReqValid && ctlStatus[3] && !ctlStatus[5] &&
        !loaderBusy |=> ctlStatus[5]) else $error("request not taken");
    AST_DETECT_CLR: assert property ($fell(ctlStatus[3]) |-> $past(statusWrite) &&
        ($past(statusWdata) & 8'h08) != 8'h00) else $error("detect flag lost");
    AST_NACK_END: assert property ($rose(ctlStatus[1]) |->
        ctlStatus[5] ##[1:400] !ctlStatus[5]) else $error("no idle after nack");
    AST_LOAD_PULSE: assert property (loadValid |-> loaderBusy ##1 !loadValid)
        else $error("load pulse wrong");
    cover property (loadValid);
    cover property ($rose(ctlStatus[1]));
    cover property ($rose(ctlStatus[0]));
endmodule

bind serial_bus_master serial_bus_monitor mon (.clock, .reset, .swReqValid, .statusWrite,
    .statusWdata, .sharedPin1Out, .sharedPin1Oe, .sharedPin4Out, .sharedPin4Oe, .ctlStatus,
    .loaderBusy, .loadValid);

// *** dv/eeprom_model.sv ***
// Behavioural serial EEPROM answering on the two-wire bus.
`timescale 1ns/10ps
module eeprom_model #(parameter logic [6:0] ADDR = 7'h50) (
    // Resolved bus lines, and the model's pull on data.
    input  wire logic scl,
    input  wire logic sda,
    output logic      sdaOe
);
    logic [7:0] mem [256];
    logic [7:0] sh, ptr;
    logic       act, rd, tx;
    int         bitN, ph;
    initial sdaOe = 1'b0;
    initial act = 1'b0;
    // Start and stop are data edges while the clock is high.
    always @(negedge sda) if (scl === 1'b1) begin
        bitN = 0;
        ph = 0;
        {act, rd, tx} = 3'h4;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    // Bits are taken on the rising clock; a read ends on a not-acknowledge.
    always @(posedge scl) begin
        if (bitN < 8) sh = {sh[6:0], sda};
        if (bitN == 8 && tx) ptr++;
        if (bitN == 8 && tx && sda) act = 1'b0;
        bitN++;
    end
    // Data moves only while the clock is low.
    always @(negedge scl) begin
        if (act && bitN == 8 && !tx) begin
            if (ph == 0) {act, rd} = {sh[7:1] == ADDR, sh[0]};
            if (ph == 1) ptr = sh;
            if (ph == 2) mem[ptr] = sh;
            if (ph == 2) ptr++;
            ph = (ph == 0) ? 1 : 2;
            sdaOe = act;
        end else begin
            if (bitN == 9) bitN = 0;
            if (bitN == 0) tx = rd;
            sdaOe = act && tx && bitN < 8 && !mem[ptr][7 - bitN];
        end
    end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the two-wire serial bus master.
`timescale 1ns/10ps
module tb;
    logic                      clock, reset, strap, swReqValid, statusWrite;
    logic                      sclOe, sdaOe, slvOe, loaderBusy, loadValid;
    logic [7:0]                statusWdata, ctlStatus, readData;
    serial_bus_pkg::sw_req_t   swReq;
    serial_bus_pkg::load_out_t loadOut, lastLoad;
    int                        errTotal, checksDone, cycles, loadCnt;
    // Pull-ups: a released line reads high.
    wire scl = ~sclOe;
    wire sda = ~(sdaOe | slvOe);
    serial_bus_master dut (.clock, .reset, .strapPinA(strap), .strapPinB(strap),
        .sharedPin1In(sda), .sharedPin1Out(), .sharedPin1Oe(sdaOe), .sharedPin4In(scl),
        .sharedPin4Out(), .sharedPin4Oe(sclOe), .swReqValid, .swReq, .statusWrite,
        .statusWdata, .ctlStatus, .readData, .loaderBusy, .loadValid, .loadOut);
    eeprom_model slv (.scl, .sda, .sdaOe(slvOe));
    // Clock.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Cycle ceiling and capture of loader results.
    always @(posedge clock) begin
        cycles++;
        if (loadValid === 1'b1) lastLoad <= loadOut;
        if (loadValid === 1'b1) loadCnt++;
        if (cycles == 80000) errTotal++;
        if (cycles == 80000) wrapUp;
    end
    task automatic chk(string what, logic [39:0] got, logic [39:0] exp);
        checksDone++;
        if (got !== exp) errTotal++;
        if (got !== exp) $display("[FAIL] %s expected %h seen %h", what, exp, got);
    endtask
    task automatic doReset;
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (20) @(posedge clock);
    endtask
    // Waits, with a bound, until neither software nor loader is busy.
    task automatic waitIdle;
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((ctlStatus[5] | loaderBusy) !== 1'b0 && n < 40000);
        chk("idle", 40'(n < 40000), 40'h1);
    endtask
    task automatic req(logic [6:0] a, logic d, logic [7:0] v);
        @(posedge clock);
        swReqValid <= 1'b1;
        swReq <= {a, d, 8'h20, v};
        @(posedge clock);
        swReqValid <= 1'b0;
        @(posedge clock);
        waitIdle;
    endtask
    task automatic wrStatus(logic [7:0] v);
        @(posedge clock);
        statusWrite <= 1'b1;
        statusWdata <= v;
        @(posedge clock);
        statusWrite <= 1'b0;
        @(negedge clock);
    endtask
    // One entry then the end marker; a request during loading is ignored.
    task automatic testLoad;
        slv.mem[0] = 8'h01;
        for (int i = 1; i < 5; i++) slv.mem[i] = 8'(8'h11 * i);
        slv.mem[8] = 8'hff;
        slv.mem[8'h20] = 8'h00;
        doReset;
        req(7'h50, 1'b0, 8'h99);
        chk("loadOut", 40'(lastLoad), {8'h01, 32'h11223344});
        chk("loads", 40'(loadCnt), 40'h1);
        chk("refused", 40'(slv.mem[8'h20]), 40'h0);
        chk("detect", 40'(ctlStatus[3]), 40'h1);
        chk("loadErr", 40'(ctlStatus[0]), 40'h0);
        $display("load test done");
    endtask
    // Byte write then read back to back.
    task automatic testRw;
        req(7'h50, 1'b0, 8'h5a);
        chk("written", 40'(slv.mem[8'h20]), 40'h5a);
        req(7'h50, 1'b1, 8'h00);
        chk("readData", 40'(readData), 40'h5a);
        chk("nackErr", 40'(ctlStatus[1]), 40'h0);
        $display("read write test done");
    endtask
    // Unanswered address: error flag, no write, flag cleared by a one.
    task automatic testNack;
        req(7'h23, 1'b0, 8'h77);
        chk("nackErr", 40'(ctlStatus[1]), 40'h1);
        chk("kept", 40'(slv.mem[8'h20]), 40'h5a);
        wrStatus(8'h02);
        chk("nackClr", 40'(ctlStatus[1]), 40'h0);
        $display("nack test done");
    endtask
    task automatic testDetect;
        wrStatus(8'h00);
        chk("detectKept", 40'(ctlStatus[3]), 40'h1);
        wrStatus(8'h08);
        chk("detectClr", 40'(ctlStatus[3]), 40'h0);
        $display("detect test done");
    endtask
    // A bad offset reference aborts loading.
    task automatic testLoadErr;
        slv.mem[0] = 8'h05;
        loadCnt = 0;
        doReset;
        waitIdle;
        chk("loadErr", 40'(ctlStatus[0]), 40'h1);
        chk("loads", 40'(loadCnt), 40'h0);
        $display("load error test done");
    endtask
    // Straps low: nothing detected, lines left alone, requests ignored.
    task automatic testNoBus;
        @(posedge clock);
        strap <= 1'b0;
        doReset;
        req(7'h50, 1'b0, 8'h33);
        chk("noBus", 40'(ctlStatus), 40'h0);
        chk("noWrite", 40'(slv.mem[8'h20]), 40'h5a);
        $display("no bus test done");
    endtask
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        {reset, strap} = 2'h3;
        {swReqValid, statusWrite, swReq, statusWdata} = '0;
        testLoad;
        testRw;
        testNack;
        testDetect;
        testLoadErr;
        testNoBus;
        wrapUp;
    end
endmodule
